//--- rtl/cag_addr_gen.v
// Program counter and operand effective address generation.
`timescale 1ns/10ps
`include "cag_defs.vh"
// How it works
// [RULE1] Sequential PC advances by instruction byte count
// [RULE2] Relative branch: next start plus signed displacement
// [RULE3] Short branch and conditional branches use relative
// [RULE4] Absolute call and branch load 16-bit field
// [RULE5] Table call loads destination from 40H-7FH table
// [RULE6] Register branch loads accumulator pair into PC
// [RULE7] Direct address is instruction 16-bit immediate
// [RULE8] Short direct selects within FE20H to FF1FH
// [RULE9] Bit 8 set for fields 00H-1FH only
// [RULE10] RAM FE20H-FEFFH, peripherals FF00H-FF1FH in window
// [RULE11] Word short direct accesses use even addresses; not enforced here, bit 0 of the field passes through unchanged
// [RULE12] Peripheral addressing selects page FF00H to FFFFH
// [RULE13] FF00H-FF1FH reachable by both addressing forms
// [RULE14] Based: zero-extended offset plus base, no carry
// [RULE15] Three-bit code selects one of eight registers
// [RULE16] Short direct high bits ones, low byte unchanged
// [RULE17] Table entry at 40H plus twice index
module cag_addr_gen (
   input  wire        clk_sys_i,
   input  wire        rst_i,
   input  wire        pc_load_i,
   input  wire [2:0]  pc_mode_i,
   input  wire [1:0]  instr_len_i,
   input  wire        branch_taken_i,
   input  wire [7:0]  branch_displacement_i,
   input  wire [15:0] absolute_address_field_i,
   input  wire [7:0]  opcode_i,
   input  wire [15:0] accumulator_pair_i,
   input  wire [15:0] base_pair_i,
   input  wire [2:0]  ea_mode_i,
   input  wire [7:0]  operand_field_i,
   input  wire [63:0] reg_file_i,
   input  wire [2:0]  reg_code_i,
   input  wire [7:0]  mem_rdata_i,
   output reg  [15:0] pc_o,
   output reg  [15:0] ea_o,
   output reg         ea_is_ram_o,
   output reg         ea_is_periph_o,
   output reg  [7:0]  reg_value_o,
   output reg  [15:0] table_addr_o,
   output reg         table_rd_o,
   output reg         busy_o
);
   reg  [15:0] pc_q;
   reg  [15:0] pc_d;
   reg  [2:0]  state_q;
   reg  [7:0]  table_lo_q;
   reg  [15:0] ea_d;
   wire [15:0] next_start;
   wire [15:0] rel_target;
   wire [15:0] table_entry;
   wire [4:0]  table_index_field;
   wire [7:0]  reg_sel;
   reg  [2:0]  state_d;
   wire        table_start;
   wire        table_done;
   wire        pc_direct;
   wire [15:0] table_pc;
   wire        ram_hit;
   wire        periph_hit;

   // One-hot states of the table read sequence.
   localparam ST_IDLE     = 3'h1;
   localparam ST_TABLE_LO = 3'h2;
   localparam ST_TABLE_HI = 3'h4;

   assign next_start = pc_q + {14'h0000, instr_len_i}; // see [RULE1]
   // Sign extension of bit 7 gives the -128 to +127 reach.
   assign rel_target = next_start
                     + {{8{branch_displacement_i[7]}},
                        branch_displacement_i}; // see [RULE2]
   assign table_index_field = opcode_i[5:1];
   assign table_entry = `CAG_TABLE_BASE
                      + {10'h000, table_index_field, 1'h0}; // see [RULE17]

   cag_reg_select u_reg_select (
      .reg_file_i  (reg_file_i),
      .reg_code_i  (reg_code_i),
      .reg_value_o (reg_sel)
   );

   always @* begin
      pc_d = next_start;
      case (pc_mode_i)
         `CAG_PC_MODE_REL: begin
            // Untaken conditional branches fall through.
            if (branch_taken_i) begin
               pc_d = rel_target; // see [RULE3]
            end
         end
         `CAG_PC_MODE_ABS: begin
            pc_d = absolute_address_field_i; // see [RULE4]
         end
         `CAG_PC_MODE_PAIR: begin
            pc_d = accumulator_pair_i; // see [RULE6]
         end
         default: begin
            pc_d = next_start;
         end
      endcase
   end

   always @* begin
      ea_d = absolute_address_field_i; // see [RULE7]
      case (ea_mode_i)
         `CAG_EA_MODE_SHORT: begin
            // Word accesses rely on the core giving an even field.
            ea_d = {`CAG_SHORT_HIGH,
                    (operand_field_i < `CAG_SHORT_BIT8_LIMIT),
                    operand_field_i}; // see [RULE8] [RULE9] [RULE16]
         end
         `CAG_EA_MODE_PERIPH: begin
            ea_d = {`CAG_PERIPH_PAGE, operand_field_i}; // see [RULE12]
         end
         `CAG_EA_MODE_BASED: begin
            ea_d = base_pair_i + {8'h00, operand_field_i}; // see [RULE14]
         end
         default: begin
            ea_d = absolute_address_field_i;
         end
      endcase
   end

   // Loads are taken only while idle. A load that arrives during a
   // table read is dropped, not queued, so the core must repeat it.
   assign table_start = pc_load_i && (state_q == ST_IDLE)
                      && (pc_mode_i == `CAG_PC_MODE_TABLE);
   assign pc_direct   = pc_load_i && (state_q == ST_IDLE)
                      && (pc_mode_i != `CAG_PC_MODE_TABLE);
   assign table_done  = (state_q == ST_TABLE_HI);
   // The high byte is taken straight off the bus in its own cycle.
   assign table_pc    = {mem_rdata_i, table_lo_q}; // see [RULE5]
   assign ram_hit     = (ea_d[15:8] == `CAG_RAM_PAGE)
                      && (ea_d[7:0] >= `CAG_RAM_START); // see [RULE10]
   // Both forms reach FF00H-FF1FH, so the page alone decides.
   assign periph_hit  = (ea_d[15:8] == `CAG_PERIPH_PAGE); // see [RULE13]

   // Two memory cycles fetch the destination, one byte in each.
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (table_start) begin
               state_d = ST_TABLE_LO;
            end
         end
         ST_TABLE_LO: begin
            state_d = ST_TABLE_HI;
         end
         ST_TABLE_HI: begin
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         ea_o           <= 16'h0000;
         ea_is_ram_o    <= 1'h0;
         ea_is_periph_o <= 1'h0;
         reg_value_o    <= 8'h00;
      end else begin
         ea_o           <= ea_d;
         ea_is_ram_o    <= ram_hit; // see [RULE10]
         ea_is_periph_o <= periph_hit; // see [RULE13]
         reg_value_o    <= reg_sel; // see [RULE15]
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         state_q <= ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         table_lo_q   <= 8'h00;
         table_addr_o <= 16'h0000;
         table_rd_o   <= 1'h0;
         busy_o       <= 1'h0;
      end else begin
         case (state_q)
            ST_IDLE: begin
               table_rd_o <= table_start;
               busy_o     <= table_start;
               if (table_start) begin
                  table_addr_o <= table_entry; // see [RULE5]
               end
            end
            ST_TABLE_LO: begin
               // Low byte first: the table entry is little-endian.
               table_lo_q   <= mem_rdata_i;
               table_addr_o <= table_addr_o + 16'h0001;
            end
            ST_TABLE_HI: begin
               table_rd_o <= 1'h0;
               busy_o     <= 1'h0;
            end
            default: begin
               table_rd_o <= 1'h0;
               busy_o     <= 1'h0;
            end
         endcase
      end
   end

   always @(posedge clk_sys_i) begin
      if (rst_i) begin
         pc_q <= `CAG_PC_RESET;
         pc_o <= `CAG_PC_RESET;
      end else if (table_done) begin
         pc_q <= table_pc; // see [RULE5]
         pc_o <= table_pc;
      end else if (pc_direct) begin
         pc_q <= pc_d;
         pc_o <= pc_d;
      end
   end
endmodule // cag_addr_gen

//--- rtl/cag_defs.vh
// Constants for the CPU address generation block.
`ifndef CAG_DEFS_VH
`define CAG_DEFS_VH
`define CAG_PC_MODE_SEQ      3'h0
`define CAG_PC_MODE_REL      3'h1
`define CAG_PC_MODE_ABS      3'h2
`define CAG_PC_MODE_TABLE    3'h3
`define CAG_PC_MODE_PAIR     3'h4
`define CAG_EA_MODE_DIRECT   3'h0
`define CAG_EA_MODE_SHORT    3'h1
`define CAG_EA_MODE_PERIPH   3'h2
`define CAG_EA_MODE_BASED    3'h3
`define CAG_TABLE_BASE       16'h0040
`define CAG_SHORT_HIGH       7'h7F
`define CAG_SHORT_BIT8_LIMIT 8'h20
`define CAG_PERIPH_PAGE      8'hFF
`define CAG_PC_RESET         16'h0000
`define CAG_RAM_PAGE         8'hFE
`define CAG_RAM_START        8'h20
`endif

//--- rtl/cag_reg_select.v
// Eight-way general register selector for register operand addressing.
`timescale 1ns/10ps
`include "cag_defs.vh"
module cag_reg_select (
   input  wire [63:0] reg_file_i,
   input  wire [2:0]  reg_code_i,
   output wire [7:0]  reg_value_o
);
   assign reg_value_o = reg_file_i[{reg_code_i, 3'h0} +: 8]; // see [RULE15]
endmodule // cag_reg_select

//--- test/cag_mem_model.sv
// Program memory model that serves the table reads.
`timescale 1ns/10ps
module cag_mem_model (
   input  wire        table_rd_i,
   input  wire [15:0] table_addr_i,
   output wire [7:0]  rdata_o
);
   reg [7:0] last_q = 8'h00;
   // An idle bus shows the inverse of the last byte, so late reads show up.
   assign rdata_o = table_rd_i ? table_addr_i[7:0] * 8'h1D + 8'h5B : ~last_q;
   always @* if (table_rd_i) last_q = rdata_o;
endmodule // cag_mem_model

//--- test/cag_addr_gen_properties.sv
// Checker on the address generation ports.
`timescale 1ns/10ps
module cag_addr_gen_properties (
   input wire        clk_sys_i,
   input wire        rst_i,
   input wire        pc_load_i,
   input wire [2:0]  pc_mode_i,
   input wire [1:0]  instr_len_i,
   input wire        branch_taken_i,
   input wire [7:0]  branch_displacement_i,
   input wire [15:0] absolute_address_field_i,
   input wire [7:0]  opcode_i,
   input wire [15:0] accumulator_pair_i,
   input wire [15:0] base_pair_i,
   input wire [2:0]  ea_mode_i,
   input wire [7:0]  operand_field_i,
   input wire [7:0]  mem_rdata_i,
   input wire [15:0] pc_o,
   input wire [15:0] ea_o,
   input wire        ea_is_ram_o,
   input wire        ea_is_periph_o,
   input wire [15:0] table_addr_o,
   input wire        table_rd_o,
   input wire        busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (rst_i);
   // A load counts only when the block is idle.
   wire ld = pc_load_i && !busy_o;
   AST_SEQ: assert property (
      ld && pc_mode_i == 3'h0 |=> pc_o == $past(pc_o) + $past(instr_len_i))
      else $error("seq pc");
   AST_REL: assert property (
      ld && pc_mode_i == 3'h1 && branch_taken_i |=>
      pc_o == $past(pc_o) + $past(instr_len_i)
         + $past({{8{branch_displacement_i[7]}}, branch_displacement_i}))
      else $error("rel pc");
   AST_ABS: assert property (
      ld && pc_mode_i == 3'h2 |=> pc_o == $past(absolute_address_field_i))
      else $error("abs pc");
   AST_PAIR: assert property (
      ld && pc_mode_i == 3'h4 |=> pc_o == $past(accumulator_pair_i))
      else $error("pair pc");
   AST_TBL: assert property (
      ld && pc_mode_i == 3'h3 |=> table_rd_o
      && table_addr_o == 16'h0040 + {$past(opcode_i[5:1]), 1'h0}
      ##2 pc_o == {$past(mem_rdata_i), $past(mem_rdata_i, 2)} && !busy_o)
      else $error("table pc");
   AST_DIRECT: assert property (
      ea_mode_i == 3'h0 |=> ea_o == $past(absolute_address_field_i))
      else $error("direct ea");
   AST_SHORT: assert property (
      ea_mode_i == 3'h1 |=> ea_o == $past(operand_field_i)
         + ($past(operand_field_i) < 8'h20 ? 16'hFF00 : 16'hFE00))
      else $error("short ea");
   AST_PERIPH: assert property (
      ea_mode_i == 3'h2 |=> ea_o == {8'hFF, $past(operand_field_i)})
      else $error("periph ea");
   AST_BASED: assert property (
      ea_mode_i == 3'h3 |=> ea_o == $past(base_pair_i + operand_field_i))
      else $error("based ea");
   AST_RAM: assert property (
      ea_is_ram_o == (ea_o >= 16'hFE20 && ea_o < 16'hFF00))
      else $error("ram flag");
   AST_PERIPH_FLAG: assert property (
      ea_is_periph_o == (ea_o >= 16'hFF00)) else $error("periph flag");
   cover property (ld && pc_mode_i == 3'h3);
   cover property (ld && pc_mode_i == 3'h1 && branch_taken_i);
   cover property (ea_mode_i == 3'h1 && operand_field_i < 8'h20);
   cover property (ea_is_ram_o);
endmodule // cag_addr_gen_properties
bind cag_addr_gen cag_addr_gen_properties cag_addr_gen_properties_inst (
   .clk_sys_i                (clk_sys_i),
   .rst_i                    (rst_i),
   .pc_load_i                (pc_load_i),
   .pc_mode_i                (pc_mode_i),
   .instr_len_i              (instr_len_i),
   .branch_taken_i           (branch_taken_i),
   .branch_displacement_i    (branch_displacement_i),
   .absolute_address_field_i (absolute_address_field_i),
   .opcode_i                 (opcode_i),
   .accumulator_pair_i       (accumulator_pair_i),
   .base_pair_i              (base_pair_i),
   .ea_mode_i                (ea_mode_i),
   .operand_field_i          (operand_field_i),
   .mem_rdata_i              (mem_rdata_i),
   .pc_o                     (pc_o),
   .ea_o                     (ea_o),
   .ea_is_ram_o              (ea_is_ram_o),
   .ea_is_periph_o           (ea_is_periph_o),
   .table_addr_o             (table_addr_o),
   .table_rd_o               (table_rd_o),
   .busy_o                   (busy_o)
);

//--- test/cag_addr_gen_tb.sv
// Self-checking bench for the address generation block.
`timescale 1ns/10ps
module cag_addr_gen_tb;
   reg         clk_sys_i = 1'b0, rst_i = 1'b1, ld, tk, ram_x, per_x;
   reg  [1:0]  len;
   reg  [2:0]  pm, em, rc;
   reg  [7:0]  bd, op, of, rv_x;
   reg  [15:0] af, ap, bp, pc_x = 16'h0000, ea_x, tb_x;
   reg  [63:0] rf;
   reg  [95:0] r;
   wire [15:0] pc, ea, ta;
   wire [7:0]  rv, md;
   wire        tr, bz, ram, per;
   integer     seed = 32'h018da52e, miscompares = 0, compares = 0, n, bsy = 0;
   cag_addr_gen cag_addr_gen_inst (.clk_sys_i(clk_sys_i), .rst_i(rst_i),
      .pc_load_i(ld), .pc_mode_i(pm), .instr_len_i(len), .branch_taken_i(tk),
      .branch_displacement_i(bd), .absolute_address_field_i(af),
      .opcode_i(op), .accumulator_pair_i(ap), .base_pair_i(bp), .ea_mode_i(em),
      .operand_field_i(of), .reg_file_i(rf), .reg_code_i(rc), .mem_rdata_i(md),
      .pc_o(pc), .ea_o(ea), .ea_is_ram_o(ram), .ea_is_periph_o(per),
      .reg_value_o(rv), .table_addr_o(ta), .table_rd_o(tr), .busy_o(bz));
   cag_mem_model cag_mem_model_inst (.table_rd_i(tr), .table_addr_i(ta),
      .rdata_o(md));
   function [7:0] tv(input [15:0] a);
      tv = a[7:0] * 8'h1D + 8'h5B;
   endfunction
   task chk(input [15:0] g, input [15:0] x);
      begin
         compares = compares + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
         end
      end
   endtask
   task finish_test;
      begin
         $display("compares %0d miscompares %0d", compares, miscompares);
         if (miscompares == 0 && compares > 0)
            $display("bench passed");
         else
            $display("bench failed");
         $finish;
      end
   endtask
   initial forever #4 clk_sys_i = ~clk_sys_i;
   initial begin
      {ld, pm, len, tk, bd, af, op, ap, bp, em, of, rc, rf} = '0;
      repeat (2) @(negedge clk_sys_i);
      for (n = 0; n < 3000; n = n + 1) begin
         // One cycle of reset mid-run must bring every output back to zero.
         rst_i = (n == 1500);
         r = {$random(seed), $random(seed), $random(seed)};
         {ld, pm, len, tk, bd, af, op, ap, bp, em, of, rc} = r[84:0];
         // Word short direct accesses keep their field even.
         if (em == 3'h1 && n[2]) of[0] = 1'h0;
         rf = {$random(seed), $random(seed)};
         rv_x = rf[rc * 8 +: 8];
         case (em)
            3'h1: ea_x = {8'hFE, of} + (of < 8'h20 ? 16'h0100 : 16'h0000);
            3'h2: ea_x = {8'hFF, of};
            3'h3: ea_x = bp + of;
            default: ea_x = af;
         endcase
         // A load while the table read runs is refused and lost.
         if (bsy > 0) begin
            bsy = bsy - 1;
            if (bsy == 0) pc_x = {tv(tb_x + 16'h0001), tv(tb_x)};
         end else if (ld) begin
            case (pm)
               3'h1: pc_x = pc_x + len + (tk ? {{8{bd[7]}}, bd} : 16'h0000);
               3'h2: pc_x = af;
               3'h3: begin
                  bsy = 2;
                  tb_x = 16'h0040 + {op[5:1], 1'h0};
               end
               3'h4: pc_x = ap;
               default: pc_x = pc_x + len;
            endcase
         end
         if (rst_i) begin
            pc_x = 16'h0000;
            bsy = 0;
            ea_x = 16'h0000;
            rv_x = 8'h00;
         end
         ram_x = (ea_x >= 16'hFE20 && ea_x <= 16'hFEFF);
         per_x = (ea_x >= 16'hFF00);
         @(negedge clk_sys_i);
         chk(pc, pc_x);
         chk(ea, ea_x);
         chk({15'h0000, ram}, {15'h0000, ram_x});
         chk({15'h0000, per}, {15'h0000, per_x});
         chk({8'h00, rv}, {8'h00, rv_x});
         chk({15'h0000, bz}, {15'h0000, bsy != 0});
         chk({15'h0000, tr}, {15'h0000, bsy != 0});
         if (bsy > 0) chk(ta, bsy == 2 ? tb_x : tb_x + 16'h0001);
      end
      finish_test;
   end
endmodule // cag_addr_gen_tb
